// ==== hw/fbcd_host.v ====
// Host-side controller that turns simple operations into flash bus cycles.
// Assumes the flash pins are synchronous to i_clock and tied through a
// bench model; data bus is split into out, in and output enable.
`timescale 1ns/1ps
`include "fbcd_map.vh"

module fbcd_host #(
    parameter AW = 26,
    parameter WP_CYC = `FBCD_T_WP_CYC,
    parameter ACC_CYC = `FBCD_T_ACC_CYC
) (
    input wire i_clock,
    input wire i_nrst,
    input wire i_req,
    input wire [2:0] i_op,
    input wire [AW-1:0] i_addr,
    input wire [15:0] i_data,
    output reg o_busy,
    output reg o_done,
    output reg [15:0] o_rdata,
    output reg [AW-1:0] o_flash_addr,
    output reg [15:0] o_flash_dq,
    output reg o_flash_dq_oe,
    input wire [15:0] i_flash_dq,
    output reg o_flash_ce_n,
    output reg o_flash_we_n,
    output reg o_flash_oe_n
);

// ==========================================================
// Reset release
reg rst_s1;
reg rst_n;
always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
        rst_s1 <= 1'b0;
        rst_n <= 1'b0;
    end else begin
        rst_s1 <= 1'b1;
        rst_n <= rst_s1;
    end
end

// ==========================================================
// Sequencer state
localparam ST_IDLE = 2'h0;
localparam ST_SETUP = 2'h1;
localparam ST_PULSE = 2'h2;
localparam ST_GAP = 2'h3;
// Gap cycle also gives the data bus a turn-around before any read

reg [1:0] state;
reg [2:0] step;
reg [2:0] last;
reg [2:0] op;
reg [AW-1:0] addr;
reg [15:0] data;
reg [7:0] cnt;
reg rd;

// Unlock cycles drive the upper address bits as zero; the flash only
// looks at the low bits of a command address.
// Cycle table: address and data of bus cycle 'step' for the latched op
reg [AW-1:0] cyc_addr;
reg [15:0] cyc_data;
reg cyc_rd;
always @* begin
    cyc_addr = {{(AW-12){1'b0}}, `FBCD_ADDR_UNLOCK1};
    cyc_data = data;
    cyc_rd = 1'b0;
    case (op)
        `FBCD_OP_RESET: begin
            cyc_data = `FBCD_CMD_RESET;
        end
        `FBCD_OP_SR_READ: begin
            if (step == 3'h0) begin
                cyc_data = `FBCD_CMD_SR_READ;
            end else begin
                cyc_addr = addr;
                cyc_rd = 1'b1;
            end
        end
        `FBCD_OP_SR_CLEAR: begin
            cyc_data = `FBCD_CMD_SR_CLEAR;
        end
        `FBCD_OP_PROGRAM, `FBCD_OP_WB_START: begin
            case (step)
                3'h0: cyc_data = `FBCD_DATA_UNLOCK1;
                3'h1: begin
                    cyc_addr = {{(AW-12){1'b0}}, `FBCD_ADDR_UNLOCK2};
                    cyc_data = `FBCD_DATA_UNLOCK2;
                end
                3'h2: begin
                    if (op == `FBCD_OP_PROGRAM) begin
                        cyc_data = `FBCD_CMD_PROGRAM;
                    end else begin
                        cyc_addr = addr;
                        cyc_data = `FBCD_CMD_WB_LOAD;
                    end
                end
                default: begin
                    cyc_addr = addr; // (data or word count)
                    cyc_data = data;
                end
            endcase
        end
        `FBCD_OP_WB_WORD: begin
            cyc_addr = addr;
        end
        `FBCD_OP_WB_CONFIRM: begin
            cyc_addr = addr;
            cyc_data = `FBCD_CMD_WB_CONFIRM;
        end
        default: begin
            cyc_addr = addr;
            cyc_rd = 1'b1;
        end
    endcase
end

// Status read is a write then a read; program and load take four writes
// Number of bus cycles per op, minus one
reg [2:0] op_last;
always @* begin
    case (i_op)
        `FBCD_OP_SR_READ: op_last = 3'h1;
        `FBCD_OP_PROGRAM: op_last = 3'h3;
        `FBCD_OP_WB_START: op_last = 3'h3;
        default: op_last = 3'h0;
    endcase
end

// ==========================================================
// Bus-cycle engine: setup, strobe for WP_CYC or ACC_CYC, then gap
// Limitations: a sequence is never cut short once taken; the caller
// recovers a confused flash with op 0, which sends the reset code.
// Completion of an embedded program is not tracked here: the caller
// polls with op 1 and reads the status bits itself.
// Writes to the device's non-volatile registers wear the whole register
// array, so callers should batch them; nothing here issues them.
// One bus cycle costs 2 + WP_CYC (write) or 2 + ACC_CYC (read) clocks.
always @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
        state <= ST_IDLE;
        step <= 3'h0;
        last <= 3'h0;
        op <= 3'h0;
        addr <= {AW{1'b0}};
        data <= 16'h0000;
        cnt <= 8'h00;
        rd <= 1'b0;
        o_busy <= 1'b0;
        o_done <= 1'b0;
        o_rdata <= 16'h0000;
        o_flash_addr <= {AW{1'b0}};
        o_flash_dq <= 16'h0000;
        o_flash_dq_oe <= 1'b0;
        o_flash_ce_n <= 1'b1;
        o_flash_we_n <= 1'b1;
        o_flash_oe_n <= 1'b1;
    end else begin
        o_done <= 1'b0;
        case (state)
            ST_IDLE: begin
                if (i_req) begin
                    op <= i_op;
                    addr <= i_addr;
                    data <= i_data;
                    last <= op_last;
                    step <= 3'h0;
                    o_busy <= 1'b1;
                    state <= ST_SETUP;
                end
            end
            ST_SETUP: begin
                // Address, data and strobes launch together; the latch is on the strobe's rise
                o_flash_addr <= cyc_addr;
                o_flash_dq <= cyc_data;
                o_flash_dq_oe <= ~cyc_rd;
                rd <= cyc_rd;
                o_flash_ce_n <= 1'b0;
                o_flash_we_n <= cyc_rd;
                o_flash_oe_n <= ~cyc_rd;
                cnt <= cyc_rd ? ACC_CYC[7:0] : WP_CYC[7:0];
                state <= ST_PULSE;
            end
            ST_PULSE: begin
                if (cnt > 8'h01) begin
                    cnt <= cnt - 8'h01;
                end else begin
                    if (rd) begin
                        o_rdata <= i_flash_dq;
                    end
                    // Rising write strobe latches the command in the flash;
                    // chip enable stays low one more cycle so the latch
                    // never races the chip enable release
                    o_flash_we_n <= 1'b1;
                    o_flash_oe_n <= 1'b1;
                    state <= ST_GAP;
                end
            end
            default: begin
                // Hold data one cycle past the strobe edge, then next cycle
                o_flash_dq_oe <= 1'b0;
                o_flash_ce_n <= 1'b1; // Deselect after the write has latched
                if (step == last) begin
                    o_busy <= 1'b0;
                    o_done <= 1'b1;
                    state <= ST_IDLE;
                end else begin
                    step <= step + 3'h1;
                    state <= ST_SETUP;
                end
            end
        endcase
    end
end

endmodule

// ==== hw/fbcd_map.vh ====
// Constants for the host-side flash command sequencer.
// Assumes an asynchronous x16 NOR flash behind a simple bus-cycle engine.
// How it works
// - Write F0 anywhere returns device to reading
// - Status read: 70 at 555, then read
// - Status clear: single 71 at 555
// - Word program: AA, 55, A0, then data
// - Buffer load: unlock, 25, count, then pairs
// - Confirm buffer with 29 at sector address
`ifndef FBCD_MAP_VH
`define FBCD_MAP_VH
// ==========================================================
// Command codes and unlock addresses
`define FBCD_ADDR_UNLOCK1 12'h555
`define FBCD_ADDR_UNLOCK2 12'h2AA
`define FBCD_DATA_UNLOCK1 16'h00AA
`define FBCD_DATA_UNLOCK2 16'h0055
`define FBCD_CMD_RESET 16'h00F0
`define FBCD_CMD_SR_READ 16'h0070
`define FBCD_CMD_SR_CLEAR 16'h0071
`define FBCD_CMD_PROGRAM 16'h00A0
`define FBCD_CMD_WB_LOAD 16'h0025
`define FBCD_CMD_WB_CONFIRM 16'h0029
// ==========================================================
// Operation selectors on the host command port
`define FBCD_OP_RESET 3'h0
`define FBCD_OP_SR_READ 3'h1
`define FBCD_OP_SR_CLEAR 3'h2
`define FBCD_OP_PROGRAM 3'h3
`define FBCD_OP_WB_START 3'h4
`define FBCD_OP_WB_WORD 3'h5
`define FBCD_OP_WB_CONFIRM 3'h6
`define FBCD_OP_READ 3'h7
// ==========================================================
// Bus timing, in ns and derived 8 ns cycles (least times round up)
`define FBCD_CLK_NS 8
`define FBCD_T_WP_NS 35
`define FBCD_T_WP_CYC ((`FBCD_T_WP_NS + `FBCD_CLK_NS - 1) / `FBCD_CLK_NS)
`define FBCD_T_ACC_NS 100
`define FBCD_T_ACC_CYC ((`FBCD_T_ACC_NS + `FBCD_CLK_NS - 1) / `FBCD_CLK_NS)
`endif

// ==== testbench/fbcd_flash_model.sv ====
// Behavioural flash answering host bus cycles.
// Assumes writes latch on the rising write strobe.
`timescale 1ns/1ps
module fbcd_flash_model (
    input wire [25:0] i_addr,
    input wire [15:0] i_dq,
    input wire i_ce_n,
    input wire i_we_n,
    input wire i_oe_n,
    output wire [15:0] o_dq
);
    // ========================
    // Array, status and command state
    reg [15:0] mem [256];
    reg [15:0] sr = 16'h0090;
    reg srm = 0;
    int st = 0;
    int n;
    int qa [$];
    reg [15:0] qd [$];
    wire [11:0] a = i_addr[11:0];
    // No register commands arrive here, so no register array wear is kept
    wire [15:0] rd = srm ? sr : mem[i_addr[7:0]];
    // Released bus flips, so a stale value never passes
    assign o_dq = (!i_ce_n && !i_oe_n) ? rd : ~rd;
    initial foreach (mem[i]) mem[i] = 16'hFFFF;
    // Status mode covers one read only
    always @(posedge i_oe_n) srm = 0;
    // Decode each write cycle
    always @(posedge i_we_n) if (!i_ce_n) begin
        if (i_dq == 16'h00F0) begin
            srm = 0;
            st = 7;
        end
        if (st == 0 && a == 12'h555 && i_dq == 16'h0070)
            srm = 1;
        if (st == 0 && a == 12'h555 && i_dq == 16'h0071)
            sr = 16'h0080;
        if (st == 3)
            mem[i_addr[7:0]] = i_dq;
        if (st == 4) begin
            n = i_dq;
            qa.delete();
            qd.delete();
        end
        if (st == 5) begin
            qa.push_back(i_addr);
            qd.push_back(i_dq);
        end
        if (st == 6 && i_dq == 16'h0029)
            foreach (qa[i]) mem[qa[i][7:0]] = qd[i];
        case (st)
            0: st = (a == 12'h555 && i_dq == 16'h00AA) ? 1 : 0;
            1: st = (a == 12'h2AA && i_dq == 16'h0055) ? 2 : 0;
            2: st = (i_dq == 16'h00A0) ? 3 : (i_dq == 16'h0025) ? 4 : 0;
            4: st = 5;
            5: st = (qa.size() == n) ? 6 : 5;
            default: st = 0;
        endcase
    end
endmodule

// ==== testbench/fbcd_host_test.sv ====
// Self-checking bench for the host flash sequencer.
// Assumes default bus timing and the behavioural flash model.
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fails++; $display("wrong value %0t %h %h", $time, g, e); end end
module fbcd_host_test;
    reg clk = 0;
    reg nrst = 0;
    reg req = 0;
    reg [2:0] op = 0;
    reg [25:0] addr = 0;
    reg [15:0] data = 0;
    integer fails = 0;
    integer checked = 0;
    integer cyc = 0;
    reg busy_seen = 0;
    reg idle_seen = 0;
    wire busy, done, dq_oe, ce_n, we_n, oe_n;
    wire [15:0] rdata, h_dq, m_dq;
    wire [25:0] f_addr;
    wire [15:0] bus = dq_oe ? h_dq : m_dq;
    fbcd_host u_dut (.i_clock(clk), .i_nrst(nrst), .i_req(req), .i_op(op), .i_addr(addr), .i_data(data),
        .o_busy(busy), .o_done(done), .o_rdata(rdata), .o_flash_addr(f_addr), .o_flash_dq(h_dq), .o_flash_dq_oe(dq_oe),
        .i_flash_dq(bus), .o_flash_ce_n(ce_n), .o_flash_we_n(we_n), .o_flash_oe_n(oe_n));
    fbcd_flash_model u_flash (.i_addr(f_addr), .i_dq(bus), .i_ce_n(ce_n), .i_we_n(we_n), .i_oe_n(oe_n), .o_dq(m_dq));
    // ========================
    // Clock, hang guard and verdict
    initial forever #4 clk = ~clk;
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 3000) begin
            fails++;
            results;
        end
    end
    task results;
        begin
            $display("fails %0d checked %0d", fails, checked);
            if (fails == 0 && checked > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    // One op, raised at a falling edge, bounded wait for done
    task run(input [2:0] o, input [25:0] a, input [15:0] d);
        integer n;
        begin
            @(negedge clk);
            req = 1;
            op = o;
            addr = a;
            data = d;
            @(negedge clk);
            req = 0;
            busy_seen = busy;
            for (n = 0; n < 99 && done !== 1'b1; n++) @(negedge clk);
            idle_seen = busy;
            if (done !== 1'b1) begin
                fails++;
                results;
            end
        end
    endtask
    task t_status;
        begin
            run(3'h1, 26'h0, 16'h0000);
            `CHK(rdata, 16'h0090)
            run(3'h2, 26'h0, 16'h0000);
            run(3'h1, 26'h3, 16'h0000);
            `CHK(rdata, 16'h0080)
            run(3'h7, 26'h3, 16'h0000);
            `CHK(rdata, 16'hFFFF)
        end
    endtask
    task t_buffer;
        begin
            run(3'h4, 26'h10000, 16'h0002);
            run(3'h5, 26'h10010, 16'h1111);
            run(3'h5, 26'h10011, 16'h2222);
            run(3'h7, 26'h10010, 16'h0000);
            `CHK(rdata, 16'hFFFF)
            run(3'h6, 26'h10000, 16'h0000);
            run(3'h7, 26'h10011, 16'h0000);
            `CHK(rdata, 16'h2222)
        end
    endtask
    // Abort a load midway, then program one word
    task t_abort;
        begin
            run(3'h4, 26'h0, 16'h0002);
            run(3'h5, 26'h20, 16'h3333);
            run(3'h0, 26'h0, 16'h0000);
            run(3'h3, 26'h2000021, 16'h4444);
            `CHK({busy_seen, idle_seen}, 2'h2)
            run(3'h7, 26'h20, 16'h0000);
            `CHK(rdata, 16'hFFFF)
            run(3'h7, 26'h2000021, 16'h0000);
            `CHK(rdata, 16'h4444)
        end
    endtask
    initial begin
        repeat (20) @(negedge clk);
        nrst = 1;
        repeat (3) @(negedge clk);
        t_status;
        t_buffer;
        t_abort;
        results;
    end
endmodule

// ==== testbench/fbcd_monitor.sv ====
// Checker for the command cycles at the flash pins.
// Assumes it is bound into fbcd_host.
`timescale 1ns/1ps
module fbcd_monitor #(parameter AW = 26) (
    input wire i_clock,
    input wire i_nrst,
    input wire i_req,
    input wire [2:0] i_op,
    input wire [AW-1:0] i_addr,
    input wire o_busy,
    input wire [AW-1:0] o_flash_addr,
    input wire [15:0] o_flash_dq,
    input wire o_flash_we_n
);
    // ========================
    // First write lands two edges after the op is taken
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_nrst);
    wire [3:0] k = {i_req && !o_busy, i_op};
    wire [15:0] d = o_flash_dq;
    wire w = !o_flash_we_n;
    wire u = w && o_flash_addr[11:0] == 12'h555;
    AST_F0: assert property (k == 4'h8 |-> ##2 w && d == 16'h00F0) else $error("bad reset");
    AST_SR: assert property (k == 4'h9 |-> ##2 u && d == 16'h0070) else $error("bad status");
    AST_CLR: assert property (k == 4'hA |-> ##2 (u && d == 16'h0071) [*5] ##1 !w) else $error("bad clear");
    AST_PGM: assert property (k == 4'hB |-> ##2 u && d == 16'h00AA) else $error("bad program");
    AST_WB: assert property (k == 4'hC |-> ##2 u && d == 16'h00AA) else $error("bad load");
    AST_CNF: assert property (k == 4'hE |-> ##2 w && d == 16'h0029 &&
        o_flash_addr == $past(i_addr, 2)) else $error("bad confirm");
    cover property (k == 4'hD);
    cover property (k == 4'hE);
    cover property (k == 4'hF);
endmodule
bind fbcd_host fbcd_monitor #(.AW(AW)) u_mon (.i_clock(i_clock), .i_nrst(i_nrst), .i_req(i_req), .i_op(i_op),
    .i_addr(i_addr), .o_busy(o_busy), .o_flash_addr(o_flash_addr), .o_flash_dq(o_flash_dq), .o_flash_we_n(o_flash_we_n));
